// ### core/cms_defs.svh
/*
 * Constants of the configuration memory scrubber: record layout, reset
 * values, check-word polynomial and reader indices.
 * Assumes inclusion by bare name from core/.
 */
`ifndef CMS_DEFS_SVH
`define CMS_DEFS_SVH

`define CMS_REC_W        78
`define CMS_SLICE_W      128
`define CMS_SLICE_WORDS  4
`define CMS_CHK_W        32
`define CMS_NUM_RD       3
`define CMS_RD_FABRIC    0
`define CMS_RD_JTAG      1
`define CMS_RD_PROC      2
`define CMS_CRC_POLY     32'h04c11db7
`define CMS_CRC_INIT     32'hffffffff

`define CMS_F_FADDR_LSB  0
`define CMS_F_FADDR_W    16
`define CMS_F_CDW_LSB    16
`define CMS_F_CDW_W      2
`define CMS_F_CBIT_LSB   18
`define CMS_F_CBIT_W     5
`define CMS_F_CTYPE_LSB  23
`define CMS_F_CTYPE_W    3
`define CMS_F_SYN_LSB    26
`define CMS_F_SYN_W      32
`define CMS_F_FDW_LSB    58
`define CMS_F_FDW_W      10
`define CMS_F_FBIT_LSB   68
`define CMS_F_FBIT_W     5
`define CMS_F_FTYPE_LSB  73
`define CMS_F_FTYPE_W    3
`define CMS_F_RSVD       76
`define CMS_F_CUPD       77

`define CMS_T_NONE       3'h0
`define CMS_T_SINGLE     3'h1
`define CMS_T_UNCORR     3'h7
`define CMS_REC_RST      78'h0

`endif

// ### core/cms_pkg.sv
/*
 * Types and check-word functions shared by the scrubber and its column
 * engines. Assumes cms_defs.svh is reachable by bare name.
 */
`include "cms_defs.svh"

package cms_pkg;

    typedef enum logic [2:0] {
        ST_IDLE, ST_REQ, ST_RUN, ST_FCHK, ST_PEND, ST_GAP, ST_REPORT
    } cms_state_t;

    typedef enum logic [1:0] {
        PS_VERIFY, PS_COMPUTE, PS_SCRUB, PS_LOCATE
    } cms_pass_t;

    typedef logic [`CMS_SLICE_WORDS-1:0][`CMS_CHK_W-1:0] cms_fold_t;

    // One 32-bit word folded into a running check word
    function automatic logic [31:0] cms_crc_step(input logic [31:0] c,
                                                 input logic [31:0] w);
        logic [31:0] r;
        r = c;
        for (int i = 31; i >= 0; i--) begin
            if (r[31] ^ w[i]) begin
                r = {r[30:0], 1'b0} ^ `CMS_CRC_POLY;
            end else begin
                r = {r[30:0], 1'b0};
            end
        end
        return r;
    endfunction : cms_crc_step

    // Frame check word over the per-position fold of all column slices
    function automatic logic [31:0] cms_frame_chk(input cms_fold_t f);
        logic [31:0] r;
        r = `CMS_CRC_INIT;
        for (int k = 0; k < `CMS_SLICE_WORDS; k++) begin
            r = cms_crc_step(r, f[k]);
        end
        return r;
    endfunction : cms_frame_chk

endpackage : cms_pkg

// ### core/cms_col_if.sv
/*
 * Link between the scrubber sequencer and one column checking engine.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
`include "cms_defs.svh"

interface cms_col_if;
    logic [`CMS_SLICE_W-1:0] slice;
    logic                    start;
    logic                    first;
    logic                    close;
    logic                    store;
    logic                    done;
    logic                    mismatch;

    modport ctl (output slice, start, first, close, store,
                 input  done, mismatch);
    modport eng (input  slice, start, first, close, store,
                 output done, mismatch);
endinterface : cms_col_if

// ### core/cms_col_engine.sv
/*
 * Column checking engine: folds one 128-bit slice per frame into a
 * running column check word, four words in four cycles, and either stores
 * the result or compares it against the stored word at pass end.
 * Assumes the sequencer starts at most one slice per five cycles.
 */
`timescale 1ns/1ps
`include "cms_defs.svh"

module cms_col_engine
    import cms_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    cms_col_if.eng   cif
);

    typedef struct packed {
        logic                    busy;
        logic [1:0]              cnt;
        logic [`CMS_SLICE_W-1:0] sl;
        logic [`CMS_CHK_W-1:0]   acc;
        logic [`CMS_CHK_W-1:0]   chk;
    } cms_eng_st_t;

    cms_eng_st_t q_r;
    cms_eng_st_t q_nxt;

    always_comb begin
        q_nxt = q_r;
        if (cif.start) begin
            q_nxt.busy = 1'b1;
            q_nxt.cnt  = 2'h0;
            q_nxt.sl   = cif.slice;
            if (cif.first) begin
                q_nxt.acc = `CMS_CRC_INIT;
            end
        end else if (q_r.busy) begin
            q_nxt.acc = cms_crc_step(q_r.acc, q_r.sl[{q_r.cnt, 5'h00} +: 32]); // RULE4
            q_nxt.cnt = q_r.cnt + 2'h1;
            if (q_r.cnt == 2'(`CMS_SLICE_WORDS - 1)) begin
                q_nxt.busy = 1'b0;
            end
        end
        if (cif.close && cif.store) begin
            q_nxt.chk = q_r.acc; // RULE14
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            q_r <= '0;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign cif.done     = q_r.busy && (q_r.cnt == 2'(`CMS_SLICE_WORDS - 1));
    assign cif.mismatch = q_r.acc != q_r.chk;

    sequence seq_slice_run;
        !cif.done [*3] ##1 cif.done;
    endsequence

    AST_SLICE_FOUR: assert property ( // RULE4
        @(posedge clk_sys) disable iff (reset)
        cif.start |=> seq_slice_run)
        else $error("slice not finished in four cycles");

endmodule : cms_col_engine

// ### core/cms_scrubber.sv
/*
 * Background configuration memory scrubber: load-time checksum and frame
 * check word generation, user-mode frame and column checking passes,
 * error pin, error record and three update/shift copies of it.
 * Assumes frame data arrives whole on frame_vld after frame_req.
 */
`timescale 1ns/1ps
`include "cms_defs.svh"

// Operation
// RULE1: In user mode, frames are read repeatedly and sent to the checkers.
// RULE2: A soft error found raises the dedicated error pin.
// RULE3: Checksum errors are also caught while configuration loads.
// RULE4: Each column engine takes 128 bits per frame, done in four cycles.
// RULE5: A pass reads every frame before it counts as complete.
// RULE6: Every detected error rewrites the record with its details; a compute-pass error only sets the CUPD bit.
// RULE7: Fabric update register loads the record one cycle after valid.
// RULE8: Reader holds the fabric enable before transfer; no overwrite then.
// RULE9: Fabric shift register lets user logic shift the copy out.
// RULE10: A JTAG update and shift pair gives out the record copy.
// RULE11: JTAG update loads one cycle after valid; transfer needs enable.
// RULE12: Processor pair works the same way over its own interface.
// RULE13: Each frame has a 32-bit check word over 128-bit slices.
// RULE14: Each column has a 32-bit check word held in registers.
// RULE15: Frame words made during load; column words only after it.
// RULE16: Entering user mode with checking on starts frame-word validation; once verified, the code goes to the compute or scrub pass.
// RULE17: Column words are computed only after the first frame pass.
// RULE18: Column words recomputed after reconfiguration, partial or protocol.
// RULE19: Column engines run in parallel, count set by frame length.
// RULE20: Record is 78 bits, no location for uncorrectable errors.
// RULE21: Pin rises on detection and falls when the record is ready; after a compute-pass error cupd keeps err_pin high.
// RULE22: Correctable errors give a column pulse then a frame pulse.
// RULE23: Reader drops the enable after shifting so updates resume.
// RULE24: After the last frame the scan wraps to frame zero.
module cms_scrubber
    import cms_pkg::*;
#(
    parameter int FRAME_BITS = 512,
    parameter int NUM_FRAMES = 16
) (
    input  wire logic                  clk_sys,
    input  wire logic                  reset,
    input  wire logic                  user_mode,
    input  wire logic                  check_en,
    input  wire logic                  cfg_valid,
    input  wire logic [31:0]           cfg_word,
    input  wire logic                  cfg_end,
    input  wire logic [31:0]           cfg_crc,
    input  wire logic                  reconfig_done,
    input  wire logic                  pr_done,
    input  wire logic                  cvp_done,
    output logic                       frame_req,
    output logic [15:0]                frame_addr,
    input  wire logic                  frame_vld,
    input  wire logic [FRAME_BITS-1:0] frame_data,
    input  wire logic [31:0]           frame_chk,
    output logic                       fchk_wr,
    output logic [15:0]                fchk_frame,
    output logic [31:0]                fchk_word,
    output logic                       err_pin,
    output logic                       load_err,
    input  wire logic [2:0]            rd_ce,
    input  wire logic [2:0]            rd_load,
    input  wire logic [2:0]            rd_shift,
    output logic [2:0]                 rd_sout
);

    localparam int NUM_COL = FRAME_BITS / `CMS_SLICE_W; // RULE19
    localparam int WPF     = NUM_COL * `CMS_SLICE_WORDS;
    localparam logic [15:0] LAST_FR = 16'(NUM_FRAMES - 1);
    localparam logic [15:0] LAST_WD = 16'(WPF - 1);

    typedef logic [`CMS_REC_W-1:0] cms_rec_t;

    typedef struct packed {
        cms_state_t                  st;
        cms_pass_t                   ps;
        logic [15:0]                 fadr;
        logic [31:0]                 syn;
        logic [15:0]                 col;
        logic                        verified;
        logic                        recal;
        logic                        pin;
        logic                        cupd;
        cms_rec_t                    rec;
        logic                        rvld;
        logic [15:0]                 lwc;
        logic [15:0]                 lfr;
        cms_fold_t                   fold;
        logic [31:0]                 lcrc;
        logic                        lerr;
        logic                        fwr;
        logic [31:0]                 fwd;
        logic [15:0]                 ffr;
        logic [`CMS_NUM_RD-1:0][`CMS_REC_W-1:0] upd;
        logic [`CMS_NUM_RD-1:0][`CMS_REC_W-1:0] shf;
    } cms_top_st_t;

    cms_top_st_t       q_r;
    cms_top_st_t       q_nxt;
    cms_fold_t         sfold;
    logic [NUM_COL-1:0] mm;
    logic              eng_start;
    logic              eng_close;
    logic [15:0]       first_col;
    logic [1:0]        n_mm;

    cms_col_if cif[NUM_COL] ();

    // Parallel column engines, one per 128-bit slice of a frame
    for (genvar g = 0; g < NUM_COL; g++) begin : g_col
        assign cif[g].slice = frame_data[g*`CMS_SLICE_W +: `CMS_SLICE_W]; // RULE13
        assign cif[g].start = eng_start;
        assign cif[g].first = q_r.fadr == 16'h0000;
        assign cif[g].close = eng_close;
        assign cif[g].store = q_r.ps == PS_COMPUTE; // RULE15
        assign mm[g]        = cif[g].mismatch;
        cms_col_engine u_eng (
            .clk_sys (clk_sys),
            .reset   (reset),
            .cif     (cif[g])
        ); // RULE19
    end

    assign eng_start = (q_r.st == ST_REQ) && frame_vld &&
                       (q_r.ps == PS_COMPUTE || q_r.ps == PS_SCRUB);
    assign eng_close = (q_r.st == ST_PEND) &&
                       (q_r.ps == PS_COMPUTE || q_r.ps == PS_SCRUB);

    // Fold of the frame being read back, and column mismatch summary
    always_comb begin
        sfold     = '0;
        first_col = 16'h0000;
        n_mm      = 2'h0;
        for (int c = 0; c < NUM_COL; c++) begin
            for (int k = 0; k < `CMS_SLICE_WORDS; k++) begin
                sfold[k] = sfold[k] ^
                           frame_data[c*`CMS_SLICE_W + k*32 +: 32];
            end
        end
        for (int c = NUM_COL - 1; c >= 0; c--) begin
            if (mm[c]) begin
                first_col = 16'(c);
                n_mm      = (n_mm == 2'h0) ? 2'h1 : 2'h2;
            end
        end
    end

    always_comb begin
        q_nxt      = q_r;
        q_nxt.rvld = 1'b0;
        q_nxt.fwr  = 1'b0;
        // Load path: frame check words and stream checksum
        if (cfg_valid) begin
            q_nxt.fold[q_r.lwc[1:0]] = q_r.fold[q_r.lwc[1:0]] ^ cfg_word;
            q_nxt.lcrc = cms_crc_step(q_r.lcrc, cfg_word); // RULE3
            if (q_r.lwc == LAST_WD) begin
                q_nxt.fwr  = 1'b1; // RULE15
                q_nxt.fwd  = cms_frame_chk(q_nxt.fold); // RULE13
                q_nxt.ffr  = q_r.lfr;
                q_nxt.lfr  = q_r.lfr + 16'h0001;
                q_nxt.lwc  = 16'h0000;
                q_nxt.fold = '0;
            end else begin
                q_nxt.lwc = q_r.lwc + 16'h0001;
            end
        end
        if (cfg_end) begin
            if (q_nxt.lcrc != cfg_crc) begin
                q_nxt.lerr = 1'b1; // RULE3
            end
            q_nxt.lcrc     = `CMS_CRC_INIT;
            q_nxt.lfr      = 16'h0000;
            q_nxt.lwc      = 16'h0000;
            q_nxt.fold     = '0;
            q_nxt.verified = 1'b0;
        end
        // Scrub sequencer
        case (q_r.st)
            ST_IDLE: begin
                if (user_mode && check_en) begin
                    q_nxt.fadr = 16'h0000;
                    q_nxt.st   = ST_REQ; // RULE16
                    if (!q_r.verified) begin
                        q_nxt.ps = PS_VERIFY;
                    end else if (q_r.recal) begin
                        q_nxt.ps    = PS_COMPUTE;
                        q_nxt.recal = 1'b0;
                    end else begin
                        q_nxt.ps = PS_SCRUB;
                    end
                end
            end
            ST_REQ: begin
                if (frame_vld) begin
                    q_nxt.syn = cms_frame_chk(sfold) ^ frame_chk; // RULE1
                    q_nxt.st  = eng_start ? ST_RUN : ST_FCHK;
                end
            end
            ST_RUN: begin
                if (cif[0].done) begin
                    q_nxt.st = ST_FCHK;
                end
            end
            ST_FCHK: begin
                if (q_r.syn != 32'h0 && q_r.ps == PS_COMPUTE) begin
                    q_nxt.cupd             = 1'b1;
                    q_nxt.rec[`CMS_F_CUPD] = 1'b1;
                    q_nxt.pin              = 1'b1;
                    q_nxt.st               = ST_REPORT;
                end else if (q_r.syn != 32'h0 && q_r.ps != PS_SCRUB) begin
                    if (q_r.ps == PS_VERIFY) begin
                        q_nxt.rec = `CMS_REC_RST;
                    end
                    q_nxt.rec[`CMS_F_FADDR_LSB +: `CMS_F_FADDR_W] = q_r.fadr;
                    q_nxt.rec[`CMS_F_SYN_LSB +: `CMS_F_SYN_W] = q_r.syn; // RULE6
                    q_nxt.rec[`CMS_F_FDW_LSB +: `CMS_F_FDW_W] =
                        (q_r.ps == PS_LOCATE) ? {q_r.col[7:0], 2'h0} : 10'h0;
                    q_nxt.rec[`CMS_F_FTYPE_LSB +: `CMS_F_FTYPE_W] =
                        `CMS_T_SINGLE;
                    q_nxt.pin = 1'b1; // RULE2
                    q_nxt.st  = ST_REPORT; // RULE22
                end else if (q_r.fadr == LAST_FR) begin
                    q_nxt.st = ST_PEND; // RULE5
                end else begin
                    q_nxt.fadr = q_r.fadr + 16'h0001;
                    q_nxt.st   = ST_REQ;
                end
            end
            ST_PEND: begin
                q_nxt.fadr = 16'h0000;
                q_nxt.st   = ST_REQ; // RULE24
                case (q_r.ps)
                    PS_VERIFY: begin
                        q_nxt.verified = 1'b1;
                        q_nxt.ps       = PS_COMPUTE; // RULE17
                        q_nxt.recal    = 1'b0;
                    end
                    PS_COMPUTE: begin
                        q_nxt.ps = PS_SCRUB;
                    end
                    PS_SCRUB: begin
                        if (q_r.recal) begin
                            q_nxt.ps    = PS_COMPUTE; // RULE18
                            q_nxt.recal = 1'b0;
                        end else if (n_mm == 2'h1) begin
                            q_nxt.rec = `CMS_REC_RST;
                            q_nxt.rec[`CMS_F_CTYPE_LSB +: `CMS_F_CTYPE_W] =
                                `CMS_T_SINGLE;
                            q_nxt.col = first_col;
                            q_nxt.pin = 1'b1; // RULE22
                            q_nxt.ps  = PS_LOCATE;
                            q_nxt.st  = ST_GAP;
                        end else if (n_mm == 2'h2) begin
                            q_nxt.rec = `CMS_REC_RST; // RULE20
                            q_nxt.rec[`CMS_F_CTYPE_LSB +: `CMS_F_CTYPE_W] =
                                `CMS_T_UNCORR;
                            q_nxt.pin = 1'b1; // RULE2
                            q_nxt.st  = ST_REPORT;
                        end
                    end
                    default: begin
                        q_nxt.rec = `CMS_REC_RST; // RULE20
                        q_nxt.rec[`CMS_F_CTYPE_LSB +: `CMS_F_CTYPE_W] =
                            `CMS_T_UNCORR;
                        q_nxt.rec[`CMS_F_FTYPE_LSB +: `CMS_F_FTYPE_W] =
                            `CMS_T_UNCORR;
                        q_nxt.pin = 1'b1;
                        q_nxt.st  = ST_REPORT;
                    end
                endcase
            end
            ST_GAP: begin
                q_nxt.pin = 1'b0;
                q_nxt.st  = ST_REQ;
            end
            default: begin
                q_nxt.pin  = 1'b0; // RULE21
                q_nxt.rvld = 1'b1;
                if (q_r.ps == PS_LOCATE || q_r.ps == PS_SCRUB) begin
                    q_nxt.ps   = PS_SCRUB;
                    q_nxt.fadr = 16'h0000;
                    q_nxt.st   = ST_REQ;
                end else if (q_r.fadr == LAST_FR) begin
                    q_nxt.st = ST_PEND;
                end else begin
                    q_nxt.fadr = q_r.fadr + 16'h0001;
                    q_nxt.st   = ST_REQ;
                end
            end
        endcase
        // Set after the sequencer so a request never loses to a clear
        if (reconfig_done || pr_done || cvp_done) begin
            q_nxt.recal = 1'b1; // RULE18
        end
        if (!(user_mode && check_en)) begin
            q_nxt.st  = ST_IDLE;
            q_nxt.pin = 1'b0;
        end
        // Update/shift copies of the record for the three readers
        for (int i = 0; i < `CMS_NUM_RD; i++) begin
            if (q_r.rvld && !rd_ce[i]) begin
                q_nxt.upd[i] = q_r.rec; // RULE7 RULE11 RULE12
            end
            if (rd_ce[i] && rd_load[i]) begin
                q_nxt.shf[i] = q_r.upd[i]; // RULE8 RULE10
            end else if (rd_shift[i]) begin
                q_nxt.shf[i] = q_r.shf[i] >> 1; // RULE9
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            q_r      <= '0;
            q_r.lcrc <= `CMS_CRC_INIT;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign frame_req  = q_r.st == ST_REQ;
    assign frame_addr = q_r.fadr;
    assign fchk_wr    = q_r.fwr;
    assign fchk_frame = q_r.ffr;
    assign fchk_word  = q_r.fwd;
    assign err_pin    = q_r.pin | q_r.cupd | q_r.lerr; // RULE2
    assign load_err   = q_r.lerr;
    for (genvar r = 0; r < `CMS_NUM_RD; r++) begin : g_rd
        assign rd_sout[r] = q_r.shf[r][0];
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    sequence seq_col_pulse;
        q_r.pin ##1 !q_r.pin;
    endsequence

    AST_START_SCAN: assert property ( // RULE1
        q_r.st == ST_IDLE && user_mode && check_en |=> frame_req)
        else $error("scan did not start in user mode");
    AST_PIN_ON_ERR: assert property ( // RULE2
        q_r.st == ST_FCHK && q_r.syn != 32'h0 &&
        (q_r.ps == PS_VERIFY || q_r.ps == PS_LOCATE)
        |=> err_pin)
        else $error("error pin not raised on frame error");
    AST_LOAD_CHK: assert property ( // RULE3
        cfg_end && !cfg_valid && q_r.lcrc != cfg_crc |=> load_err)
        else $error("load checksum error missed");
    AST_PASS_END: assert property ( // RULE5
        q_r.st == ST_PEND && $past(q_r.st) == ST_FCHK
        |-> $past(q_r.fadr) == LAST_FR)
        else $error("pass ended before last frame");
    AST_UPD_FAB: assert property ( // RULE7
        q_r.rvld && !rd_ce[`CMS_RD_FABRIC]
        |=> q_r.upd[`CMS_RD_FABRIC] == $past(q_r.rec))
        else $error("fabric update register not loaded");
    AST_UPD_HOLD: assert property ( // RULE8
        rd_ce[`CMS_RD_FABRIC] |=> $stable(q_r.upd[`CMS_RD_FABRIC]))
        else $error("fabric update overwritten while enabled");
    AST_JTAG_XFER: assert property ( // RULE11
        rd_ce[`CMS_RD_JTAG] && rd_load[`CMS_RD_JTAG]
        |=> q_r.shf[`CMS_RD_JTAG] == $past(q_r.upd[`CMS_RD_JTAG]))
        else $error("jtag shift register not loaded");
    AST_UPD_PROC: assert property ( // RULE12
        q_r.rvld && !rd_ce[`CMS_RD_PROC]
        |=> q_r.upd[`CMS_RD_PROC] == $past(q_r.rec))
        else $error("processor update register not loaded");
    AST_COMPUTE_LATE: assert property ( // RULE17
        q_r.ps == PS_COMPUTE && q_r.st != ST_IDLE |-> q_r.verified)
        else $error("column words computed before verification");
    AST_RECOMPUTE: assert property ( // RULE18
        q_r.st == ST_PEND && q_r.ps == PS_SCRUB && q_r.recal
        |=> q_r.ps == PS_COMPUTE)
        else $error("column words not recomputed");
    AST_UNCORR_NOLOC: assert property ( // RULE20
        q_r.rvld && q_r.rec[`CMS_F_CTYPE_LSB +: `CMS_F_CTYPE_W] ==
        `CMS_T_UNCORR |-> q_r.rec[`CMS_F_FADDR_LSB +: `CMS_F_FADDR_W] == 16'h0)
        else $error("location reported for uncorrectable error");
    AST_PIN_READY: assert property ( // RULE21
        q_r.rvld |-> $fell(q_r.pin))
        else $error("record ready without pin falling");
    AST_TWO_PULSE: assert property ( // RULE22
        q_r.st == ST_GAP |-> seq_col_pulse ##0 q_r.ps == PS_LOCATE)
        else $error("column pulse malformed");
    AST_WRAP: assert property ( // RULE24
        q_r.st == ST_PEND && q_r.ps == PS_SCRUB && !q_r.recal && mm == '0
        && user_mode && check_en |=> q_r.fadr == 16'h0 && frame_req)
        else $error("scan did not wrap to frame zero");

endmodule : cms_scrubber

// ### test/cms_mem_model.sv
/* Frame memory model: stores loaded words and check words.
   Assumes the scrubber's frame link. */
`timescale 1ns/1ps
module cms_mem_model #(
    parameter int FB = 256,
    parameter int NF = 4
) (
    input  wire logic        clk_sys,
    input  wire logic        cfg_valid,
    input  wire logic [31:0] cfg_word,
    input  wire logic        fchk_wr,
    input  wire logic [15:0] fchk_frame,
    input  wire logic [31:0] fchk_word,
    input  wire logic        frame_req,
    input  wire logic [15:0] frame_addr,
    input  wire logic        flip,
    output logic             frame_vld = 0,
    output logic [FB-1:0]    frame_data,
    output logic [31:0]      frame_chk
);
    logic [NF*FB-1:0] mem;
    logic [31:0]      chk [NF];
    logic [FB-1:0]    cur;
    int               wi = 0;
    always_ff @(posedge clk_sys) begin
        if (cfg_valid) begin
            mem[wi*32 +: 32] <= cfg_word;
            wi <= wi + 1;
        end
        if (fchk_wr) chk[fchk_frame[1:0]] <= fchk_word;
        frame_vld <= frame_req && !frame_vld;
    end
    // Upset: bit 5 of frame 2 while flip is high
    assign cur = mem[frame_addr[1:0]*FB +: FB]
               ^ (FB'(flip && frame_addr == 16'h2) << 5);
    // Not valid: inverse, never the held value
    assign frame_data = frame_vld ? cur : ~cur;
    assign frame_chk = frame_vld ? chk[frame_addr[1:0]]
                                 : ~chk[frame_addr[1:0]];
endmodule : cms_mem_model

// ### test/tb.sv
/* Scrubber testbench. Assumes cms_mem_model as frame memory. */
`timescale 1ns/1ps
module tb;
    import cms_pkg::*;
    logic clk_sys = 0, reset = 1, user_mode = 0, check_en = 0, flip = 0;
    logic cfg_valid = 0, cfg_end = 0, frame_req, frame_vld, fchk_wr;
    logic [31:0] cfg_word = 0, cfg_crc = 0, frame_chk, fchk_word;
    logic [15:0] frame_addr, fchk_frame, exp_addr = 0;
    logic [255:0] frame_data;
    logic [2:0] rd_ce = 0, rd_load = 0, rd_shift = 0, rd_sout;
    logic err_pin, load_err, pin_q = 0, recal_req = 0;
    logic [77:0] rec;
    int err_count = 0, comparisons = 0, nwr = 0, nfr = 0, pulses = 0;
    cms_scrubber #(.FRAME_BITS(256), .NUM_FRAMES(4)) dut_u (
        .clk_sys(clk_sys), .reset(reset), .user_mode(user_mode),
        .check_en(check_en), .cfg_valid(cfg_valid), .cfg_word(cfg_word),
        .cfg_end(cfg_end), .cfg_crc(cfg_crc), .reconfig_done(recal_req),
        .pr_done(recal_req), .cvp_done(recal_req), .frame_req(frame_req),
        .frame_addr(frame_addr), .frame_vld(frame_vld),
        .frame_data(frame_data), .frame_chk(frame_chk),
        .fchk_wr(fchk_wr), .fchk_frame(fchk_frame),
        .fchk_word(fchk_word), .err_pin(err_pin), .load_err(load_err),
        .rd_ce(rd_ce), .rd_load(rd_load), .rd_shift(rd_shift),
        .rd_sout(rd_sout));
    cms_mem_model mem_u (.clk_sys(clk_sys), .cfg_valid(cfg_valid),
        .cfg_word(cfg_word), .fchk_wr(fchk_wr), .fchk_frame(fchk_frame),
        .fchk_word(fchk_word), .frame_req(frame_req),
        .frame_addr(frame_addr), .flip(flip), .frame_vld(frame_vld),
        .frame_data(frame_data), .frame_chk(frame_chk));
    initial forever #4 clk_sys = ~clk_sys;
    task automatic expect_ok(input logic ok, input string what);
        comparisons++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("BAD %0t %s", $time, what);
        end
    endtask : expect_ok
    // Frame order, pin pulses and check word writes
    always @(posedge clk_sys) begin
        pin_q <= err_pin;
        if (err_pin === 1'b1 && pin_q === 1'b0) begin
            pulses++;
            // A located error restarts the scan at frame zero
            if (pulses == 2) exp_addr <= 16'h0;
        end
        if (fchk_wr === 1'b1) nwr++;
        if (frame_req === 1'b1 && frame_vld === 1'b1) begin
            expect_ok(frame_addr === exp_addr, "frame order");
            exp_addr <= (frame_addr + 16'h1) & 16'h3;
            nfr++;
        end
    end
    task automatic t_load;
        for (int j = 0; j < 32; j++) begin
            @(negedge clk_sys) cfg_valid = 1;
            cfg_word = {8'ha5, 8'(j), 8'(~j), 8'h3c};
        end
        @(negedge clk_sys) cfg_valid = 0;
        repeat (3) @(negedge clk_sys);
        expect_ok(nwr == 4, "frame words");
    endtask : t_load
    task automatic t_scrub;
        user_mode = 1;
        check_en = 1;
        repeat (200) @(negedge clk_sys);
        recal_req = 1;
        @(negedge clk_sys) recal_req = 0;
        repeat (200) @(negedge clk_sys);
        expect_ok(nfr >= 12, "passes");
        expect_ok(pulses == 0, "false error");
    endtask : t_scrub
    task automatic unload(input int i);
        @(negedge clk_sys) rd_ce[i] = 1;
        rd_load[i] = 1;
        @(negedge clk_sys) rd_load[i] = 0;
        for (int b = 0; b < 78; b++) begin
            rec[b] = rd_sout[i];
            rd_shift[i] = 1;
            @(negedge clk_sys);
        end
        rd_shift[i] = 0;
        rd_ce[i] = 0;
    endtask : unload
    task automatic t_upset;
        flip = 1;
        for (int n = 0; n < 600 && pulses < 2; n++) @(negedge clk_sys);
        flip = 0;
        expect_ok(pulses == 2, "two pulses");
        for (int n = 0; n < 20 && err_pin; n++) @(negedge clk_sys);
        expect_ok(err_pin === 1'b0, "pin low");
        for (int i = 0; i < 3; i++) begin
            unload(i);
            expect_ok(rec[15:0] === 16'h2, "frame");
            expect_ok(rec[75:73] === 3'h1, "type");
            expect_ok(rec[67:58] === 10'h0 && !rec[77], "loc");
        end
    endtask : t_upset
    task automatic t_load_err;
        user_mode = 0;
        @(negedge clk_sys) cfg_end = 1;
        @(negedge clk_sys) cfg_end = 0;
        @(negedge clk_sys);
        expect_ok(load_err === 1'b1 && err_pin === 1'b1, "load");
    endtask : t_load_err
    task automatic wrap_up;
        $display("checks %0d errors %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : wrap_up
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_count++;
        wrap_up();
    end
    initial begin
        repeat (8) @(posedge clk_sys);
        @(negedge clk_sys) reset = 0;
        t_load();
        t_scrub();
        t_upset();
        t_load_err();
        wrap_up();
    end
endmodule : tb
